/* pkg/ipsc_pkg.sv */
/*
  Constants, state enumerations and register layout for the interrupt and
  power-save controller. Assumes nothing of its surroundings.
*/
package ipsc_pkg;
  localparam logic [7:0] IPSC_OPT_ADDR = 8'hc8;
  localparam logic [7:0] IPSC_OPT_RESET = 8'h00;
  localparam int IPSC_BIT_LEVEL = 6;
  localparam int IPSC_BIT_POL = 5;
  localparam int IPSC_BIT_GEN = 4;
  localparam logic [7:0] IPSC_OPT_MASK = 8'h70;
  // Status register, read only, holds controller state
  localparam logic [7:0] IPSC_STAT_ADDR = 8'hc9;
  localparam int IPSC_STAB_NS = 1000;
  localparam int IPSC_CLK_MHZ = 125;
  localparam int IPSC_STAB_CYC = (IPSC_STAB_NS * IPSC_CLK_MHZ + 999) / 1000;
  localparam int IPSC_NSRC = 5;
  localparam int IPSC_PC_W = 12;
  localparam logic [1:0] IPSC_FLAGSET_NORMAL = 2'h0;
  localparam logic [1:0] IPSC_FLAGSET_IRQ = 2'h1;
  localparam logic [1:0] IPSC_FLAGSET_NMI = 2'h2;
  typedef enum logic [1:0] {
    IPSC_RUN,
    IPSC_WAIT,
    IPSC_STOP,
    IPSC_STAB
  } ipsc_pwr_t;
  typedef enum logic [1:0] {
    IPSC_CTX_NORMAL,
    IPSC_CTX_IRQ,
    IPSC_CTX_NMI
  } ipsc_ctx_t;
endpackage

/* core/ipsc_src_detect.sv */
/*
  Request latch for one external interrupt line: edge or level detection.
  Assumes the line is already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ipsc_src_detect (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic line,
  input wire logic levelMode,
  input wire logic risingMode,
  input wire logic clearReq,
  output logic request
);
  typedef struct packed {
    logic prev;
    logic latch;
  } ipsc_det_t;
  ipsc_det_t s_q, s_d;
  logic edgeSeen;
  always_comb begin
    s_d = s_q;
    s_d.prev = line;
    edgeSeen = risingMode ? (line & ~s_q.prev) : (~line & s_q.prev);
    // Set wins over the clear from the core
    if (clearReq) begin
      s_d.latch = 1'b0;
    end
    if (edgeSeen && !levelMode) begin
      s_d.latch = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // Level mode stores nothing; active low line requests directly
  assign request = levelMode ? ~line : s_q.latch;
endmodule
`default_nettype wire

/* core/ipsc_top.sv */
/*
  Interrupt and power-save controller: option register, source gating,
  request selection, flag-set context, wait and stop sequencing.
  Assumes a core sequencer that strobes instruction events for one cycle
  and peripherals whose flags and enables are synchronous to clk_sys.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ipsc_top #(
  parameter int STAB_CYCLES = ipsc_pkg::IPSC_STAB_CYC,
  parameter int PC_W = ipsc_pkg::IPSC_PC_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic nmiLine,
  input wire logic src1Line,
  input wire logic src2Line,
  input wire logic timerZeroFlag,
  input wire logic timerIrqMask,
  input wire logic convDoneFlag,
  input wire logic converterIrqMask,
  input wire logic reloadWrapFlag,
  input wire logic reloadWrapIrqMask,
  input wire logic compareMatchFlag,
  input wire logic compareIrqMask,
  input wire logic inputEdgeFlag,
  input wire logic inputEdgeIrqMask,
  input wire logic watchdogActive,
  input wire logic instrEnd,
  input wire logic waitExec,
  input wire logic stopExec,
  input wire logic returnFromInterrupt,
  input wire logic [PC_W-1:0] pcIn,
  output logic takeIrq,
  output logic [2:0] irqVector,
  output logic [PC_W-1:0] pcLoad,
  output logic pcLoadValid,
  output logic [1:0] flagSet,
  output logic fetchEnable,
  output logic oscRun,
  output logic sleeping
);
  localparam int CW = $clog2(STAB_CYCLES + 1);
  initial begin
    if (STAB_CYCLES < 1 || PC_W < 1) begin
      $error("ipsc_top: bad parameter");
    end
  end

  typedef struct packed {
    logic [7:0] opt;
    ipsc_pkg::ipsc_pwr_t pwr;
    ipsc_pkg::ipsc_ctx_t ctx;
    ipsc_pkg::ipsc_ctx_t savedCtx;
    ipsc_pkg::ipsc_ctx_t nmiRetCtx;
    logic nmiLatch;
    logic nmiPrev;
    logic [PC_W-1:0] stack0;
    logic [PC_W-1:0] stack1;
    logic [CW-1:0] stabCnt;
    logic [7:0] rd;
    logic take;
    logic [2:0] vec;
    logic [PC_W-1:0] pcOut;
    logic pcValid;
    logic [1:0] flags;
    logic fetch;
    logic osc;
    logic sleep;
  } ipsc_state_t;

  ipsc_state_t s_q, s_d;
  logic req1, req2, clr1, clr2;
  logic gen, maskedPend, anyPend, wakeEv;
  logic [4:0] pend;

  function automatic logic [1:0] ctx_flags(input ipsc_pkg::ipsc_ctx_t c);
    case (c)
      ipsc_pkg::IPSC_CTX_IRQ: ctx_flags = ipsc_pkg::IPSC_FLAGSET_IRQ;
      ipsc_pkg::IPSC_CTX_NMI: ctx_flags = ipsc_pkg::IPSC_FLAGSET_NMI;
      default: ctx_flags = ipsc_pkg::IPSC_FLAGSET_NORMAL;
    endcase
  endfunction

  ipsc_src_detect u_src1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .line(src1Line),
    .levelMode(s_q.opt[ipsc_pkg::IPSC_BIT_LEVEL]),
    .risingMode(1'b0),
    .clearReq(clr1),
    .request(req1)
  );
  ipsc_src_detect u_src2 (
    .clk_sys(clk_sys),
    .reset(reset),
    .line(src2Line),
    .levelMode(1'b0),
    .risingMode(s_q.opt[ipsc_pkg::IPSC_BIT_POL]),
    .clearReq(clr2),
    .request(req2)
  );

  always_comb begin
    gen = s_q.opt[ipsc_pkg::IPSC_BIT_GEN];
    pend[0] = s_q.nmiLatch;
    pend[1] = req1;
    pend[2] = req2;
    pend[3] = (reloadWrapFlag & reloadWrapIrqMask) | (compareMatchFlag & compareIrqMask)
      | (inputEdgeFlag & inputEdgeIrqMask);
    pend[4] = (timerZeroFlag & timerIrqMask) | (convDoneFlag & converterIrqMask);
    maskedPend = gen & (|pend[4:1]);
    anyPend = maskedPend | pend[0];
    wakeEv = gen & (|pend);
    clr1 = 1'b0;
    clr2 = 1'b0;
    s_d = s_q;
    s_d.take = 1'b0;
    s_d.pcValid = 1'b0;
    s_d.nmiPrev = nmiLine;
    // Falling NMI edge latched; the clear on an NMI take wins over a set in the same cycle
    if (!nmiLine && s_q.nmiPrev) begin
      s_d.nmiLatch = 1'b1;
    end
    if (regWrite && regAddr == ipsc_pkg::IPSC_OPT_ADDR) begin
      s_d.opt = regWrData & ipsc_pkg::IPSC_OPT_MASK;
    end
    s_d.rd = 8'h00;
    if (regRead && regAddr == ipsc_pkg::IPSC_STAT_ADDR) begin
      s_d.rd = {2'h0, s_q.ctx, s_q.pwr, 1'b0, s_q.nmiLatch};
    end
    case (s_q.pwr)
      ipsc_pkg::IPSC_RUN: begin
        if (returnFromInterrupt) begin
          s_d.ctx = (s_q.ctx == ipsc_pkg::IPSC_CTX_NMI) ? s_q.nmiRetCtx : s_q.savedCtx;
          s_d.pcOut = s_q.stack0;
          s_d.stack0 = s_q.stack1;
          s_d.pcValid = 1'b1;
        end else if (instrEnd && pend[0] && s_q.ctx != ipsc_pkg::IPSC_CTX_NMI) begin
          s_d.nmiLatch = 1'b0;
          s_d.nmiRetCtx = s_q.ctx;
          s_d.ctx = ipsc_pkg::IPSC_CTX_NMI;
          s_d.stack1 = s_q.stack0;
          s_d.stack0 = pcIn;
          s_d.take = 1'b1;
          s_d.vec = 3'h0;
        end else if (instrEnd && maskedPend && s_q.ctx == ipsc_pkg::IPSC_CTX_NORMAL) begin
          // Fixed priority, source 1 highest
          s_d.vec = pend[1] ? 3'h1 : pend[2] ? 3'h2 : pend[3] ? 3'h3 : 3'h4;
          clr1 = pend[1];
          clr2 = !pend[1] && pend[2];
          s_d.savedCtx = s_q.ctx;
          s_d.ctx = ipsc_pkg::IPSC_CTX_IRQ;
          s_d.stack1 = s_q.stack0;
          s_d.stack0 = pcIn;
          s_d.take = 1'b1;
        end else if ((waitExec || stopExec) && !anyPend) begin
          s_d.fetch = 1'b0;
          s_d.sleep = 1'b1;
          if (stopExec && !watchdogActive) begin
            s_d.pwr = ipsc_pkg::IPSC_STOP;
            s_d.osc = 1'b0;
          end else begin
            s_d.pwr = ipsc_pkg::IPSC_WAIT;
          end
        end
      end
      ipsc_pkg::IPSC_WAIT: begin
        if (wakeEv) begin
          s_d.pwr = ipsc_pkg::IPSC_RUN;
          s_d.fetch = 1'b1;
          s_d.sleep = 1'b0;
        end
      end
      ipsc_pkg::IPSC_STOP: begin
        if (wakeEv) begin
          s_d.pwr = ipsc_pkg::IPSC_STAB;
          s_d.osc = 1'b1;
          s_d.stabCnt = CW'(STAB_CYCLES);
        end
      end
      ipsc_pkg::IPSC_STAB: begin
        if (s_q.stabCnt <= CW'(1)) begin
          s_d.pwr = ipsc_pkg::IPSC_RUN;
          s_d.fetch = 1'b1;
          s_d.sleep = 1'b0;
        end else begin
          s_d.stabCnt = s_q.stabCnt - CW'(1);
        end
      end
      default: s_d.pwr = ipsc_pkg::IPSC_RUN;
    endcase
    s_d.flags = ctx_flags(s_d.ctx);
    s_d.pcOut = s_d.take ? s_q.pcOut : s_d.pcOut;
  end

  always_ff @(posedge clk_sys) begin
    // reset clears option and ends sleep
    if (reset) begin
      s_q <= '0;
      s_q.opt <= ipsc_pkg::IPSC_OPT_RESET;
      s_q.pwr <= ipsc_pkg::IPSC_RUN;
      s_q.ctx <= ipsc_pkg::IPSC_CTX_NORMAL;
      s_q.nmiPrev <= 1'b1;
      s_q.fetch <= 1'b1;
      s_q.osc <= 1'b1;
      s_q.flags <= ipsc_pkg::IPSC_FLAGSET_NORMAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rd;
  assign takeIrq = s_q.take;
  assign irqVector = s_q.vec;
  assign pcLoad = s_q.pcOut;
  assign pcLoadValid = s_q.pcValid;
  assign flagSet = s_q.flags;
  assign fetchEnable = s_q.fetch;
  assign oscRun = s_q.osc;
  assign sleeping = s_q.sleep;
endmodule
`default_nettype wire

/* bench/ipsc_monitor.sv */
/* Port checker for ipsc_top.
   Assumes it is bound to ipsc_top and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ipsc_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic instrEnd,
  input wire logic waitExec,
  input wire logic stopExec,
  input wire logic watchdogActive,
  input wire logic returnFromInterrupt,
  input wire logic takeIrq,
  input wire logic [2:0] irqVector,
  input wire logic pcLoadValid,
  input wire logic [1:0] flagSet,
  input wire logic fetchEnable,
  input wire logic oscRun
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  opt_read_zero_a: assert property (regRead && regAddr == 8'hc8 |=> regRdData == 8'h00)
    else $error("option read not zero");
  take_pulse_a: assert property (takeIrq |-> $past(instrEnd) ##1 !takeIrq)
    else $error("take not one cycle after boundary");
  nmi_ctx_a: assert property (takeIrq && irqVector == 3'h0 |-> flagSet == 2'h2)
    else $error("nmi take without nmi flag set");
  irq_ctx_a: assert property (takeIrq && irqVector != 3'h0 |-> flagSet == 2'h1)
    else $error("maskable take without irq flag set");
  return_from_interrupt_pop_a: assert property (returnFromInterrupt && fetchEnable |=> pcLoadValid)
    else $error("return without pc reload");
  stop_halts_a: assert property (!oscRun |-> !fetchEnable)
    else $error("fetch with oscillator stopped");
  wait_osc_a: assert property (waitExec && fetchEnable |=> oscRun)
    else $error("wait stopped oscillator");
  wdog_stop_a: assert property (stopExec && watchdogActive |=> oscRun)
    else $error("stop honoured with watchdog on");
  stab_delay_a: assert property ($rose(oscRun) |-> (!fetchEnable) [*2])
    else $error("fetch before stabilisation");
  cover property (takeIrq && irqVector == 3'h3);
  cover property (!oscRun);
  cover property (pcLoadValid);
endmodule
bind ipsc_top ipsc_monitor u_mon (.clk_sys, .reset, .regAddr, .regRead, .regRdData, .instrEnd, .waitExec,
  .stopExec, .watchdogActive, .returnFromInterrupt, .takeIrq, .irqVector, .pcLoadValid, .flagSet,
  .fetchEnable, .oscRun);
`default_nettype wire

/* bench/ipsc_core_model.sv */
/* Core sequencer model: instruction boundaries and program counter.
   Assumes fetchEnable from ipsc_top gates all fetching. */
`timescale 1ns/1ps
`default_nettype none
module ipsc_core_model #(
  parameter int PC_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic fetchEnable,
  output logic instrEnd,
  output logic [PC_W-1:0] pcIn
);
  // Two-cycle instructions leave a gap between boundaries
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      instrEnd <= 1'h0;
      pcIn <= '0;
    end else begin
      instrEnd <= fetchEnable && !instrEnd;
      pcIn <= pcIn + PC_W'(instrEnd);
    end
  end
endmodule
`default_nettype wire

/* bench/ipsc_tb_top.sv */
/* Self-checking bench for ipsc_top.
   Assumes the core model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module ipsc_tb_top;
  logic clk_sys = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0;
  logic nmiLine = 1'h1, src1Line = 1'h1, src2Line = 1'h0, watchdogActive = 1'h0;
  logic timerZeroFlag = 1'h0, timerIrqMask = 1'h0, convDoneFlag = 1'h0, converterIrqMask = 1'h0;
  logic reloadWrapFlag = 1'h0, reloadWrapIrqMask = 1'h0, compareMatchFlag = 1'h0, compareIrqMask = 1'h0;
  logic inputEdgeFlag = 1'h0, inputEdgeIrqMask = 1'h0, waitExec = 1'h0, stopExec = 1'h0;
  logic returnFromInterrupt = 1'h0, instrEnd, takeIrq, pcLoadValid, fetchEnable, oscRun, sleeping;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
  logic [2:0] irqVector;
  logic [1:0] flagSet;
  logic [11:0] pcIn, pcLoad, pcSeen, savedPc;
  int fail_count = 0, num_checks = 0, takes = 0;
  // Short stabilisation keeps stop tests brief
  ipsc_top #(.STAB_CYCLES(4)) dut (.clk_sys, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .nmiLine, .src1Line, .src2Line, .timerZeroFlag, .timerIrqMask, .convDoneFlag, .converterIrqMask,
    .reloadWrapFlag, .reloadWrapIrqMask, .compareMatchFlag, .compareIrqMask, .inputEdgeFlag,
    .inputEdgeIrqMask, .watchdogActive, .instrEnd, .waitExec, .stopExec, .returnFromInterrupt, .pcIn,
    .takeIrq, .irqVector, .pcLoad, .pcLoadValid, .flagSet, .fetchEnable, .oscRun, .sleeping);
  ipsc_core_model u_core (.clk_sys, .reset, .fetchEnable, .instrEnd, .pcIn);
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (takeIrq === 1'h1) takes <= takes + 1;
  // Boundary PC as the core presents it; the take edge always follows a boundary by one cycle
  always @(posedge clk_sys) if (instrEnd === 1'h1) pcSeen <= pcIn;
  always @(posedge clk_sys) if (takeIrq === 1'h1) savedPc <= pcSeen;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(input logic [7:0] v);
    @(posedge clk_sys);
    {regWrite, regAddr, regWrData} <= {1'h1, 8'hc8, v};
    @(posedge clk_sys);
    regWrite <= 1'h0;
  endtask
  task core(input logic [2:0] k);
    @(posedge clk_sys);
    {returnFromInterrupt, stopExec, waitExec} <= k;
    @(posedge clk_sys);
    {returnFromInterrupt, stopExec, waitExec} <= 3'h0;
    #1;
  endtask
  task take(input logic [2:0] v);
    int t0;
    t0 = takes;
    repeat (30) if (takes == t0) tick(1);
    chk(16'(takes - t0), 16'h0001);
    chk(irqVector, v);
  endtask
  task return_from_interrupt;
    @(posedge clk_sys);
    {timerZeroFlag, convDoneFlag, reloadWrapFlag, compareMatchFlag, inputEdgeFlag, src1Line} <= 6'h01;
    core(3'h4);
    chk({pcLoadValid, flagSet}, 3'h4);
    chk(pcLoad, savedPc);
  endtask
  task t_gate;
    chk({fetchEnable, oscRun, sleeping, flagSet}, 5'h18);
    @(posedge clk_sys);
    {regRead, regAddr} <= {1'h1, 8'hc8};
    @(posedge clk_sys);
    regRead <= 1'h0;
    #1 d = regRdData;
    chk(d, 8'h00);
    @(posedge clk_sys);
    {timerZeroFlag, timerIrqMask} <= 2'h3;
    tick(10);
    chk(16'(takes), 16'h0000);
    wr(8'h9f);
    take(3'h4);
    return_from_interrupt();
  endtask
  task t_vec3;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      {reloadWrapFlag, compareMatchFlag, inputEdgeFlag} <= 3'h1 << i;
      {reloadWrapIrqMask, compareIrqMask, inputEdgeIrqMask} <= 3'h7;
      take(3'h3);
      return_from_interrupt();
    end
  endtask
  task t_edges;
    wr(8'h30);
    @(posedge clk_sys);
    src2Line <= 1'h1;
    take(3'h2);
    return_from_interrupt();
    wr(8'h10);
    @(posedge clk_sys);
    src2Line <= 1'h0;
    take(3'h2);
    return_from_interrupt();
    @(posedge clk_sys);
    src1Line <= 1'h0;
    take(3'h1);
    return_from_interrupt();
    wr(8'h50);
    @(posedge clk_sys);
    src1Line <= 1'h0;
    take(3'h1);
    return_from_interrupt();
  endtask
  task t_sleep;
    core(3'h1);
    chk({fetchEnable, oscRun, sleeping}, 3'h3);
    @(posedge clk_sys);
    {convDoneFlag, converterIrqMask} <= 2'h3;
    tick(2);
    chk(fetchEnable, 1'h1);
    take(3'h4);
    return_from_interrupt();
    core(3'h2);
    chk({fetchEnable, oscRun}, 2'h0);
    @(posedge clk_sys);
    src2Line <= 1'h1;
    tick(3);
    chk(oscRun, 1'h0);
    @(posedge clk_sys);
    src2Line <= 1'h0;
    tick(3);
    chk({fetchEnable, oscRun}, 2'h1);
    take(3'h2);
    return_from_interrupt();
    @(posedge clk_sys);
    watchdogActive <= 1'h1;
    core(3'h2);
    chk({fetchEnable, oscRun}, 2'h1);
    @(posedge clk_sys);
    timerZeroFlag <= 1'h1;
    take(3'h4);
    return_from_interrupt();
  endtask
  task t_nmi;
    wr(8'h00);
    @(posedge clk_sys);
    nmiLine <= 1'h0;
    take(3'h0);
    chk(flagSet, 2'h2);
    core(3'h1);
    @(posedge clk_sys);
    nmiLine <= 1'h1;
    tick(2);
    @(posedge clk_sys);
    nmiLine <= 1'h0;
    tick(6);
    chk(fetchEnable, 1'h0);
    @(posedge clk_sys);
    reset <= 1'h1;
    @(posedge clk_sys);
    reset <= 1'h0;
    tick(1);
    chk({fetchEnable, flagSet}, 3'h4);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'h0;
    tick(1);
    t_gate();
    t_vec3();
    t_edges();
    t_sleep();
    t_nmi();
    report_and_stop();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
